// ---- verilog/rcr_pkg.sv ----
// What this block does
// - Thermal catastrophe goes straight to S5
// - Held power button override forces S5
// - Shutdown cycle: global bit, else bit 3
// - Engine host reset, variant picks power cycle
// - Engine button override goes straight to S5
// - Engine watchdog: S5 or escalated global
// - Engine global request gives global reset
// - Power-down host reset waits for wake
// - Platform reset entry timeout forces global
// - PM watchdog or engine error: S5
// - Drop no-power-cycle reset in sleep
// - Power-cycle reset in sleep skips warning
// - Global reset: no warning, no delay
// - Missing acknowledge escalates to global reset
// - S5 moves on to deep sleep if allowed
// - Escalate watchdog/error to global from S0
// - Warn processor, await acknowledge, four seconds
package rcr_pkg;
   localparam int unsigned CLK_HZ          = 25_000_000;
   localparam int unsigned ACK_TIMEOUT_S   = 4;
   localparam int unsigned PBO_HOLD_S      = 4;
   localparam int unsigned ACK_TIMEOUT_CYC = ACK_TIMEOUT_S * CLK_HZ;
   localparam int unsigned PBO_HOLD_CYC    = PBO_HOLD_S * CLK_HZ;
   localparam int unsigned PWR_OFF_CYC     = 16;
   localparam int unsigned GRST_CYC        = 16;
   localparam int unsigned CNT_W           = 27;

   localparam logic [11:0] OFS_CTRL   = 12'h000;
   localparam logic [11:0] OFS_STATUS = 12'h004;

   localparam int unsigned CTRL_GLB_BIT  = 1;
   localparam int unsigned CTRL_PC_BIT   = 3;
   localparam int unsigned CTRL_ESC_BIT  = 4;
   localparam int unsigned CTRL_DEEP_BIT = 5;
   localparam logic [7:0]  CTRL_RST      = 8'h00;

   localparam logic [2:0] SLP_S0 = 3'h0;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_WARN   = 3'b001,
      ST_HRST   = 3'b010,
      ST_PWROFF = 3'b011,
      ST_GRST   = 3'b100,
      ST_S5     = 3'b101,
      ST_DEEP   = 3'b110
   } rcr_state_e;

   typedef enum logic [1:0] {
      OUT_HOST_NOPC = 2'b00,
      OUT_HOST_PC   = 2'b01,
      OUT_GLOBAL    = 2'b10,
      OUT_S5        = 2'b11
   } rcr_outcome_e;
endpackage : rcr_pkg

// ---- verilog/rcr_timer.sv ----
`timescale 1ns/100ps
`default_nettype none
module rcr_timer #(
   parameter int unsigned W = 27
) (
   input  wire logic         clk_sys_i,
   input  wire logic         rst_i,
   input  wire logic         start_i,
   input  wire logic [W-1:0] limit_i,
   output logic              expired_o
);
   logic [W-1:0] count_q;

   if (W < 2) begin : g_chk
      $error("rcr_timer: width too small");
   end

   // Saturates so a long hold cannot wrap back to a fresh count
   always_ff @(posedge clk_sys_i) begin
      if (rst_i || start_i) begin
         count_q <= '0;
      end else if (count_q != limit_i) begin
         count_q <= count_q + 1'b1;
      end
   end

   // Not gated by start_i: the caller derives start from this flag
   assign expired_o = (count_q == limit_i);

   property p_sat;
      @(posedge clk_sys_i) disable iff (rst_i)
      expired_o && !start_i && $stable(limit_i) |=> $stable(count_q);
   endproperty
   a_sat: assert property (p_sat)
      else $error("timer count moved past limit");
endmodule : rcr_timer
`default_nettype wire

// ---- verilog/rcr_resolver.sv ----
`timescale 1ns/100ps
`default_nettype none
module rcr_resolver
   import rcr_pkg::*;
#(
   parameter int unsigned ACK_CYC = rcr_pkg::ACK_TIMEOUT_CYC,
   parameter int unsigned PBO_CYC = rcr_pkg::PBO_HOLD_CYC
) (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        cpu_shutdown_i,
   input  wire logic        processor_power_good_i,
   input  wire logic        reset_warn_ack_i,
   input  wire logic        me_host_reset_i,
   input  wire logic        me_host_reset_pwrcyc_i,
   input  wire logic        me_host_reset_pwrdown_i,
   input  wire logic        me_pbo_i,
   input  wire logic        me_wdt_expire_i,
   input  wire logic        me_global_reset_i,
   input  wire logic        me_hw_error_i,
   input  wire logic        pm_wdt_expire_i,
   input  wire logic        thermal_catastrophic_i,
   input  wire logic        power_button_n_i,
   input  wire logic        wake_event_i,
   input  wire logic [2:0]  sleep_state_i,
   input  wire logic        sw_entered_sleep_i,
   input  wire logic        deep_sleep_cond_i,
   output logic             platform_reset_out_n_o,
   output logic             reset_warn_o,
   output logic             global_reset_o,
   output logic             host_power_cycle_o,
   output logic             force_s5_o,
   output logic             deep_sleep_state_o
);
   rcr_state_e   state_q, state_d;
   rcr_outcome_e outcome_q;
   logic [7:0]   reset_control_reg_q;
   logic [7:0]   drop_cnt_q;
   logic         pc_q, pwrdown_q;
   logic         tmr_exp, pbo_exp;
   logic [CNT_W-1:0] tmr_lim;
   logic         in_s0, busy, wd_evt, escalate;
   logic         s5_req, glob_req, host_pc, host_np, drop;
   logic         ap_setup, ap_ctrl, ap_stat;

   if (ACK_CYC >= (1 << CNT_W) || PBO_CYC >= (1 << CNT_W) ||
       ACK_CYC < 1 || PBO_CYC < 1) begin : g_chk
      $error("rcr_resolver: timeout does not fit the counter");
   end

   // Only S0 counts as awake; any other code is a sleep state S3..S5
   assign in_s0    = (sleep_state_i == SLP_S0);
   assign busy     = (state_q == ST_S5) || (state_q == ST_DEEP) ||
                     (state_q == ST_GRST);
   assign wd_evt   = me_wdt_expire_i | pm_wdt_expire_i | me_hw_error_i;
   assign escalate = reset_control_reg_q[CTRL_ESC_BIT] && in_s0;
   assign s5_req   = thermal_catastrophic_i | pbo_exp | me_pbo_i |
                     (wd_evt & !escalate);
   assign glob_req = me_global_reset_i | (wd_evt & escalate) |
                     (cpu_shutdown_i &
                      reset_control_reg_q[CTRL_GLB_BIT]);
   assign host_pc  = (cpu_shutdown_i & !reset_control_reg_q[CTRL_GLB_BIT] &
                      reset_control_reg_q[CTRL_PC_BIT]) |
                     (me_host_reset_i & me_host_reset_pwrcyc_i) |
                     me_host_reset_pwrdown_i;
   assign host_np  = (cpu_shutdown_i & !reset_control_reg_q[CTRL_GLB_BIT] &
                      !reset_control_reg_q[CTRL_PC_BIT]) |
                     (me_host_reset_i & !me_host_reset_pwrcyc_i);
   assign drop     = (state_q == ST_IDLE) && !s5_req && !glob_req &&
                     !host_pc && host_np && !in_s0;

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (host_pc) begin
               // In sleep the warning handshake has nobody to answer it
               state_d = in_s0 ? ST_WARN : ST_HRST;
            end else if (host_np && in_s0) begin
               state_d = ST_WARN;
            end
         end
         ST_WARN: begin
            if (reset_warn_ack_i) begin
               state_d = ST_HRST;
            end else if (tmr_exp) begin
               state_d = ST_GRST;
            end
         end
         ST_HRST: begin
            if (!processor_power_good_i) begin
               state_d = pc_q ? ST_PWROFF : ST_IDLE;
            end else if (tmr_exp) begin
               state_d = ST_GRST;
            end
         end
         ST_PWROFF: begin
            if (tmr_exp && (!pwrdown_q || wake_event_i)) begin
               state_d = ST_IDLE;
            end
         end
         ST_GRST: begin
            if (tmr_exp) begin
               state_d = ST_IDLE;
            end
         end
         ST_S5: begin
            if (wake_event_i) begin
               state_d = ST_IDLE;
            end else if (reset_control_reg_q[CTRL_DEEP_BIT] &&
                         deep_sleep_cond_i) begin
               state_d = ST_DEEP;
            end
         end
         ST_DEEP: begin
            if (wake_event_i) begin
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
      // Straight-to-S5 and global requests preempt any host sequence
      if (!busy && s5_req) begin
         state_d = ST_S5;
      end else if (!busy && glob_req) begin
         state_d = ST_GRST;
      end
   end

   always_comb begin
      case (state_q)
         ST_WARN, ST_HRST: tmr_lim = CNT_W'(ACK_CYC);
         ST_PWROFF:        tmr_lim = CNT_W'(PWR_OFF_CYC);
         default:          tmr_lim = CNT_W'(GRST_CYC);
      endcase
   end

   // Shared counter restarts per state; limit keyed on state_q, no loop
   rcr_timer #(.W(CNT_W)) u_seq_tmr (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .start_i   (state_d != state_q),
      .limit_i   (tmr_lim),
      .expired_o (tmr_exp)
   );

   rcr_timer #(.W(CNT_W)) u_pbo_tmr (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .start_i   (power_button_n_i),
      .limit_i   (CNT_W'(PBO_CYC)),
      .expired_o (pbo_exp)
   );

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         pc_q      <= 1'b0;
         pwrdown_q <= 1'b0;
      end else if (state_q == ST_IDLE && state_d != ST_IDLE) begin
         pc_q      <= host_pc;
         pwrdown_q <= me_host_reset_pwrdown_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         outcome_q <= OUT_HOST_NOPC;
         drop_cnt_q <= 8'h00;
      end else begin
         if (state_d != state_q) begin
            case (state_d)
               ST_S5:   outcome_q <= OUT_S5;
               ST_GRST: outcome_q <= OUT_GLOBAL;
               ST_WARN, ST_HRST: begin
                  outcome_q <= host_pc ? OUT_HOST_PC : OUT_HOST_NOPC;
               end
               default: outcome_q <= outcome_q;
            endcase
         end
         if (drop) begin
            drop_cnt_q <= drop_cnt_q + 8'h01;
         end
      end
   end

   // Outputs come from flops loaded with the next-state decode
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         platform_reset_out_n_o <= 1'b1;
         reset_warn_o           <= 1'b0;
         global_reset_o         <= 1'b0;
         host_power_cycle_o     <= 1'b0;
         force_s5_o             <= 1'b0;
         deep_sleep_state_o     <= 1'b0;
      end else begin
         platform_reset_out_n_o <= (state_d == ST_IDLE) ||
                                   (state_d == ST_WARN);
         reset_warn_o           <= (state_d == ST_WARN);
         global_reset_o         <= (state_d == ST_GRST);
         host_power_cycle_o     <= (state_d == ST_PWROFF);
         force_s5_o             <= (state_d == ST_S5) ||
                                   (state_d == ST_DEEP);
         deep_sleep_state_o     <= (state_d == ST_DEEP);
      end
   end

   // APB slave: zero wait states, read data captured in setup
   assign ap_setup  = psel_i && !penable_i;
   assign ap_ctrl   = (paddr_i == OFS_CTRL);
   assign ap_stat   = (paddr_i == OFS_STATUS);
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i && penable_i &&
                      !(ap_ctrl || (ap_stat && !pwrite_i));

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         reset_control_reg_q <= CTRL_RST;
      end else if (psel_i && penable_i && pwrite_i && ap_ctrl) begin
         reset_control_reg_q <= pwdata_i[7:0];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         prdata_o <= 32'h0000_0000;
      end else if (ap_setup && !pwrite_i) begin
         if (ap_ctrl) begin
            prdata_o <= {24'h00_0000, reset_control_reg_q};
         end else if (ap_stat) begin
            prdata_o <= {16'h0000, drop_cnt_q, 2'b00, outcome_q,
                         1'b0, state_q};
         end else begin
            prdata_o <= 32'h0000_0000;
         end
      end
   end

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   property p_thermal;
      thermal_catastrophic_i && !busy |=> state_q == ST_S5 && force_s5_o;
   endproperty
   a_thermal: assert property (p_thermal)
      else $error("thermal trip did not force S5");

   property p_pbo;
      pbo_exp && !busy |=> !platform_reset_out_n_o && state_q == ST_S5;
   endproperty
   a_pbo: assert property (p_pbo)
      else $error("button override did not force S5");

   property p_shut;
      state_q == ST_IDLE && cpu_shutdown_i && !s5_req && !glob_req &&
      in_s0 |=> state_q == ST_WARN && pc_q == $past(host_pc);
   endproperty
   a_shut: assert property (p_shut)
      else $error("shutdown cycle misclassified");

   property p_me_pbo;
      me_pbo_i && !busy |=> state_q == ST_S5;
   endproperty
   a_me_pbo: assert property (p_me_pbo)
      else $error("engine override did not force S5");

   property p_glob;
      me_global_reset_i && !busy && !s5_req |=> state_q == ST_GRST
         ##1 global_reset_o && !reset_warn_o;
   endproperty
   a_glob: assert property (p_glob)
      else $error("engine global request not honoured");

   property p_pwrdown;
      state_q == ST_PWROFF && pwrdown_q && !wake_event_i && !s5_req &&
      !glob_req |=> state_q == ST_PWROFF;
   endproperty
   a_pwrdown: assert property (p_pwrdown)
      else $error("power-down reset finished without wake");

   property p_entry_to;
      state_q == ST_HRST && processor_power_good_i && tmr_exp &&
      !s5_req |=> state_q == ST_GRST;
   endproperty
   a_entry_to: assert property (p_entry_to)
      else $error("reset entry timeout did not escalate");

   property p_drop;
      drop |=> state_q == ST_IDLE && platform_reset_out_n_o;
   endproperty
   a_drop: assert property (p_drop)
      else $error("sleep host reset was not dropped");

   property p_skip;
      state_q == ST_IDLE && host_pc && !in_s0 && !s5_req && !glob_req
      |=> state_q == ST_HRST ##1 !reset_warn_o;
   endproperty
   a_skip: assert property (p_skip)
      else $error("sleep power-cycle reset used the warning");

   property p_ack_to;
      state_q == ST_WARN && !reset_warn_ack_i && tmr_exp && !s5_req
      |=> state_q == ST_GRST ##1 global_reset_o;
   endproperty
   a_ack_to: assert property (p_ack_to)
      else $error("missing acknowledge did not escalate");

   property p_deep;
      state_q == ST_S5 && !wake_event_i && deep_sleep_cond_i &&
      reset_control_reg_q[CTRL_DEEP_BIT] |=> deep_sleep_state_o;
   endproperty
   a_deep: assert property (p_deep)
      else $error("deep sleep not entered from S5");

   property p_esc;
      wd_evt && escalate && !busy && !thermal_catastrophic_i && !pbo_exp &&
      !me_pbo_i |=> state_q == ST_GRST;
   endproperty
   a_esc: assert property (p_esc)
      else $error("watchdog did not escalate from S0");

   c_warn_ack: cover property (state_q == ST_WARN ##1 state_q == ST_HRST);
   c_ack_to:   cover property (state_q == ST_WARN ##1 state_q == ST_GRST);
   c_deep:     cover property (state_q == ST_S5 ##1 state_q == ST_DEEP);
   c_pwrdown:  cover property (state_q == ST_PWROFF && pwrdown_q &&
                               wake_event_i);
endmodule : rcr_resolver
`default_nettype wire

// ---- testbench/rcr_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module rcr_host_model (
   input  wire logic       clk_sys_i,
   input  wire logic       rst_i,
   input  wire logic [7:0] ack_dly_i,
   input  wire logic       stuck_pg_i,
   input  wire logic       reset_warn_i,
   input  wire logic       platform_reset_out_n_i,
   output logic            reset_warn_ack_o,
   output logic            processor_power_good_o
);
   logic [7:0] cnt_q;

   // Zero delay means the processor never answers the warning
   always_ff @(posedge clk_sys_i) begin
      if (rst_i || !reset_warn_i) begin
         cnt_q            <= 8'h00;
         reset_warn_ack_o <= 1'b0;
      end else begin
         cnt_q            <= cnt_q + 8'h01;
         reset_warn_ack_o <= (ack_dly_i != 8'h00) &&
                             (cnt_q + 8'h01 == ack_dly_i);
      end
   end

   // Power good drops once platform reset is seen, unless stuck high
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         processor_power_good_o <= 1'b1;
      end else begin
         processor_power_good_o <= stuck_pg_i || platform_reset_out_n_i;
      end
   end
endmodule : rcr_host_model
`default_nettype wire

// ---- testbench/test_reset_cause_resolver.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_reset_cause_resolver;
   import rcr_pkg::*;
   localparam int ACK_C = 20;
   localparam int PBO_C = 30;
   logic             clk_sys_i = 1'b0;
   logic             rst_i = 1'b1;
   logic             psel_i, penable_i, pwrite_i;
   logic [11:0]      paddr_i;
   logic [31:0]      pwdata_i;
   wire logic [31:0] prdata_o;
   wire logic        pready_o, pslverr_o, ack, pgood;
   wire logic        platform_reset_out_n_o, reset_warn_o, global_reset_o;
   wire logic        host_power_cycle_o, force_s5_o, deep_sleep_state_o;
   wire logic [5:0]  obs;
   logic [8:0]       trg;
   logic [2:0]       slp;
   logic [7:0]       ack_dly;
   logic [5:0]       seen;
   logic             pcyc, pbn, wake, dcond, stuck;
   int               mismatches, n_tests, waited;

   always #20 clk_sys_i = ~clk_sys_i;

   assign obs = {deep_sleep_state_o, force_s5_o, host_power_cycle_o,
                 global_reset_o, reset_warn_o, ~platform_reset_out_n_o};

   // Sticky record of every output seen since the last reset
   always @(posedge clk_sys_i) begin
      if (rst_i) seen <= 6'h00;
      else seen <= seen | obs;
   end

   rcr_resolver #(.ACK_CYC(ACK_C), .PBO_CYC(PBO_C)) u_dut (
      .clk_sys_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
      .cpu_shutdown_i(trg[0]), .processor_power_good_i(pgood),
      .reset_warn_ack_i(ack), .me_host_reset_i(trg[1]),
      .me_host_reset_pwrcyc_i(pcyc), .me_host_reset_pwrdown_i(trg[2]),
      .me_pbo_i(trg[3]), .me_wdt_expire_i(trg[4]),
      .me_global_reset_i(trg[5]), .me_hw_error_i(trg[6]),
      .pm_wdt_expire_i(trg[7]), .thermal_catastrophic_i(trg[8]),
      .power_button_n_i(pbn), .wake_event_i(wake), .sleep_state_i(slp),
      .sw_entered_sleep_i(slp != 3'h0), .deep_sleep_cond_i(dcond),
      .platform_reset_out_n_o, .reset_warn_o, .global_reset_o,
      .host_power_cycle_o, .force_s5_o, .deep_sleep_state_o);

   rcr_host_model u_host (
      .clk_sys_i, .rst_i, .ack_dly_i(ack_dly), .stuck_pg_i(stuck),
      .reset_warn_i(reset_warn_o),
      .platform_reset_out_n_i(platform_reset_out_n_o),
      .reset_warn_ack_o(ack), .processor_power_good_o(pgood));

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic rst_dut();
      @(posedge clk_sys_i);
      rst_i <= 1'b1;
      trg   <= 9'h000;
      slp   <= 3'h0;
      pbn   <= 1'b1;
      wake  <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'b0;
   endtask : rst_dut

   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic er);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      psel_i   <= 1'b1;
      pwrite_i <= wr;
      paddr_i  <= a;
      pwdata_i <= wd;
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (pready_o !== 1'b1 && n < 50);
      if (pready_o !== 1'b1) begin
         chk({31'h0, pready_o}, 32'h1);
         conclude();
      end
      rd = prdata_o;
      er = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb

   task automatic wait_val(input int idx, input logic v, input int lim);
      waited = 0;
      while (obs[idx] !== v) begin
         if (waited >= lim) begin
            chk({31'h0, obs[idx]}, {31'h0, v});
            conclude();
         end
         @(posedge clk_sys_i);
         waited++;
      end
   endtask : wait_val

   // md: bit0 processor silent, bit1 power good stuck, bit2 deep allowed
   task automatic go(input logic [7:0] ctrl, input logic [2:0] s,
                     input int k, input logic pc, input logic [2:0] md,
                     input int idx, input int lim, input logic [5:0] ex);
      logic [31:0] rd;
      logic        er;
      rst_dut();
      ack_dly <= md[0] ? 8'h00 : 8'h03;
      stuck   <= md[1];
      dcond   <= md[2];
      apb(1'b1, OFS_CTRL, {24'h0, ctrl}, rd, er);
      @(posedge clk_sys_i);
      slp  <= s;
      pcyc <= pc;
      trg  <= 9'h001 << k;
      @(posedge clk_sys_i);
      trg <= 9'h000;
      if (lim > 0) wait_val(idx, 1'b1, lim);
      repeat (8) @(posedge clk_sys_i);
      chk({26'h0, seen}, {26'h0, ex});
   endtask : go

   task automatic t_regs();
      logic [31:0] rd;
      logic        er;
      rst_dut();
      apb(1'b0, OFS_CTRL, 32'h0, rd, er);
      chk(rd, CTRL_RST);
      apb(1'b1, OFS_CTRL, 32'h0000_013a, rd, er);
      apb(1'b0, OFS_CTRL, 32'h0, rd, er);
      chk(rd, 32'h0000_003a);
      apb(1'b0, 12'h008, 32'h0, rd, er);
      chk({rd[30:0], er}, 32'h1);
      apb(1'b1, OFS_STATUS, 32'h0000_00ff, rd, er);
      chk({31'h0, er}, 32'h1);
      $display("test regs done");
   endtask : t_regs

   task automatic t_s5();
      go(8'h00, 3'h0, 8, 1'b0, 3'h0, 4, 4, 6'h11);
      wake <= 1'b1;
      @(posedge clk_sys_i);
      wake <= 1'b0;
      wait_val(4, 1'b0, 5);
      go(8'h00, 3'h3, 3, 1'b0, 3'h0, 4, 4, 6'h11);
      go(8'h20, 3'h0, 3, 1'b0, 3'h4, 5, 6, 6'h31);
      go(8'h20, 3'h0, 8, 1'b0, 3'h0, 4, 4, 6'h11);
      $display("test s5 done");
   endtask : t_s5

   task automatic t_button();
      rst_dut();
      pbn <= 1'b0;
      repeat (PBO_C - 4) @(posedge clk_sys_i);
      chk({26'h0, seen}, 32'h0);
      wait_val(4, 1'b1, 12);
      @(posedge clk_sys_i);
      chk({26'h0, seen}, 32'h11);
      $display("test button done");
   endtask : t_button

   task automatic t_shutdown();
      go(8'h02, 3'h0, 0, 1'b0, 3'h0, 2, 3, 6'h05);
      go(8'h08, 3'h0, 0, 1'b0, 3'h0, 3, 40, 6'h0b);
      go(8'h00, 3'h0, 0, 1'b0, 3'h0, 0, 10, 6'h03);
      $display("test shutdown done");
   endtask : t_shutdown

   task automatic t_engine();
      go(8'h00, 3'h0, 1, 1'b1, 3'h0, 3, 40, 6'h0b);
      go(8'h00, 3'h0, 1, 1'b0, 3'h0, 0, 10, 6'h03);
      go(8'h00, 3'h0, 5, 1'b0, 3'h0, 2, 3, 6'h05);
      $display("test engine done");
   endtask : t_engine

   task automatic t_wdt();
      int wk[3] = '{4, 6, 7};
      foreach (wk[i]) begin
         go(8'h00, 3'h0, wk[i], 1'b0, 3'h0, 4, 4, 6'h11);
         go(8'h10, 3'h0, wk[i], 1'b0, 3'h0, 2, 3, 6'h05);
         go(8'h10, 3'h3, wk[i], 1'b0, 3'h0, 4, 4, 6'h11);
      end
      $display("test watchdog done");
   endtask : t_wdt

   task automatic t_sleep();
      logic [31:0] rd;
      logic        er;
      go(8'h00, 3'h3, 1, 1'b0, 3'h0, 0, 0, 6'h00);
      apb(1'b0, OFS_STATUS, 32'h0, rd, er);
      chk({24'h0, rd[15:8]}, 32'h1);
      go(8'h00, 3'h4, 1, 1'b1, 3'h0, 3, 40, 6'h09);
      apb(1'b0, OFS_STATUS, 32'h0, rd, er);
      chk({26'h0, rd[5:0]}, {26'h0, OUT_HOST_PC, 1'b0, ST_PWROFF});
      $display("test sleep done");
   endtask : t_sleep

   task automatic t_timeout();
      go(8'h00, 3'h0, 1, 1'b0, 3'h1, 2, 40, 6'h07);
      chk({31'h0, waited >= ACK_C}, 32'h1);
      go(8'h00, 3'h0, 1, 1'b0, 3'h2, 2, 60, 6'h07);
      $display("test timeout done");
   endtask : t_timeout

   task automatic t_pwrdown();
      go(8'h00, 3'h0, 2, 1'b0, 3'h0, 3, 40, 6'h0b);
      // Host must stay off well past the normal power-off period
      repeat (PWR_OFF_CYC + 4) @(posedge clk_sys_i);
      chk({30'h0, obs[3], obs[0]}, 32'h3);
      wake <= 1'b1;
      @(posedge clk_sys_i);
      wake <= 1'b0;
      wait_val(3, 1'b0, 5);
      wait_val(0, 1'b0, 5);
      $display("test power down done");
   endtask : t_pwrdown

   initial begin
      {psel_i, penable_i, pwrite_i, pcyc, wake, dcond, stuck} = 7'h00;
      paddr_i  = 12'h000;
      pwdata_i = 32'h0;
      trg      = 9'h000;
      slp      = 3'h0;
      pbn      = 1'b1;
      ack_dly  = 8'h03;
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      t_regs();
      t_s5();
      t_button();
      t_shutdown();
      t_engine();
      t_wdt();
      t_sleep();
      t_timeout();
      t_pwrdown();
      conclude();
   end
endmodule : test_reset_cause_resolver
`default_nettype wire
